// ---- verilog/spi_chain_pkg.sv ----
// Constants, carriers and phase types for the chained serial write slave.
// Assumes the serial link runs on its own clock and the register bank on clk.
package spi_chain_pkg;
    localparam int BYTE_BITS = 8;
    localparam int BIT_CNT_W = 4;
    localparam logic [3:0] BIT_CNT_FULL = 4'h8;
    localparam logic [3:0] BIT_CNT_ZERO = 4'h0;
    localparam logic [2:0] POS_FIRST_IDX = 3'h3;
    localparam logic [2:0] LAST_BIT_IDX = 3'h7;
    localparam int BROADCAST_POS = 7;
    localparam int READ_POS = 6;
    localparam int POS_W = 5;
    localparam int REG_COUNT = 4;
    localparam logic [7:0] REG_LIMIT = 8'h04;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] READ_ZERO = 8'h00;
    localparam int FIFO_DEPTH = 8;
    localparam int FIFO_WIDTH = 16;

    // One accepted register write as it travels from link to bank.
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } wr_word_type;

    // Link-side pins sampled on the serial clock.
    typedef struct packed {
        logic cs_n;
        logic mosi;
    } link_in_type;

    typedef enum logic [1:0] {BYTE_CONTROL, BYTE_ADDRESS, BYTE_PAYLOAD} byte_phase_type;
endpackage : spi_chain_pkg

// ---- verilog/spi_chain_write.sv ----
// Chained serial write slave: link logic on sclk, FIFO and register bank on clk.
// Assumes mosi and cs_n change on falling sclk and the master samples on rising sclk.
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Write FIFO
// ----------------------------------------------------------------------
// Flop storage FIFO; a full FIFO drops in_ready so the producer must wait.
module write_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [PW-1:0] wr_ptr_reg;
    logic [PW-1:0] rd_ptr_reg;
    logic [PW:0] count_reg;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    // Honest flags straight from the occupancy count.
    assign in_ready = (count_reg != (PW+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign out_data = mem_reg[rd_ptr_reg];

    // Pointers wrap naturally because the depth is a power of two.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            count_reg <= count_reg + (PW+1)'(push) - (PW+1)'(pop);
        end
    end

    // Storage is written only on an accepted push.
    always_ff @(posedge clk) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end

    // The count must agree with the pointer distance and never pass the depth.
    full_stall_a: assert property (@(posedge clk) disable iff (!rstn)
        count_reg <= (PW+1)'(DEPTH) && PW'(wr_ptr_reg - rd_ptr_reg) == count_reg[PW-1:0])
        else $error("FIFO count and pointers disagree.");
endmodule : write_fifo

// ----------------------------------------------------------------------
// Top
// ----------------------------------------------------------------------
module spi_chain_write
    import spi_chain_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic sclk,
    input wire spi_chain_pkg::link_in_type link_in,
    input wire logic hold_updates,
    output logic chain_data_out,
    output logic miso_out,
    output logic miso_oe_n,
    output logic [spi_chain_pkg::REG_COUNT*8-1:0] reg_bank
);
    import spi_chain_pkg::*;

    // ------------------------------------------------------------------
    // Link reset
    // ------------------------------------------------------------------
    logic link_rst_meta_reg;
    logic link_rstn_reg;

    // The sclk may stop, so reset only reaches the link logic on its edges.
    always_ff @(posedge sclk) begin
        link_rst_meta_reg <= rstn;
        link_rstn_reg <= link_rst_meta_reg;
    end

    // ------------------------------------------------------------------
    // Link byte framing
    // ------------------------------------------------------------------
    logic [3:0] bit_cnt_reg;
    logic [3:0] bit_cnt_next;
    byte_phase_type phase_reg;
    byte_phase_type phase_next;
    logic [7:0] sh_reg;
    logic borrow_reg;
    logic pos_nz_reg;
    logic bcast_reg;
    logic rnw_reg;
    logic sel_reg;
    logic [7:0] addr_reg;
    wr_word_type word_reg;
    logic wr_toggle_reg;
    logic [7:0] tx_reg;
    logic [7:0] sync_meta_reg [REG_COUNT];
    logic [7:0] sync_bank_reg [REG_COUNT];

    // A full counter means the previous byte completed and this edge starts a new byte.
    wire new_byte = (bit_cnt_reg == BIT_CNT_FULL);
    wire [2:0] cur_idx = new_byte ? 3'h0 : bit_cnt_reg[2:0];
    wire byte_done = (cur_idx == LAST_BIT_IDX);
    wire [7:0] sh_next = {sh_reg[6:0], link_in.mosi};
    wire in_pos = (phase_next == BYTE_CONTROL) && (cur_idx >= POS_FIRST_IDX);
    wire borrow_in = (cur_idx == POS_FIRST_IDX) ? 1'b1 : borrow_reg;
    wire pos_zero = !pos_nz_reg && !link_in.mosi;
    wire addr_ok = (sh_next < REG_LIMIT);
    wire write_ok = !rnw_reg && (bcast_reg || sel_reg);
    wire read_hit = rnw_reg && sel_reg;

    // Phase moves forward only when a new byte starts after a full one.
    always_comb begin
        phase_next = phase_reg;
        if (new_byte) begin
            case (phase_reg)
                BYTE_CONTROL: phase_next = BYTE_ADDRESS;
                BYTE_ADDRESS: phase_next = BYTE_PAYLOAD;
                BYTE_PAYLOAD: phase_next = BYTE_CONTROL;
                default: phase_next = BYTE_CONTROL;
            endcase
        end
    end
    assign bit_cnt_next = {1'b0, cur_idx} + 4'h1;

    // The borrow ripples from the field's least significant bit, which arrives first.
    // The path stays combinational so chained devices add delay but no latency.
    assign chain_data_out = link_in.mosi ^ (in_pos && borrow_in);

    // A rising edge with the select released discards any partial packet.
    always_ff @(posedge sclk) begin
        if (!link_rstn_reg || link_in.cs_n) begin
            bit_cnt_reg <= BIT_CNT_ZERO;
            phase_reg <= BYTE_CONTROL;
            sh_reg <= '0;
        end else begin
            bit_cnt_reg <= bit_cnt_next;
            phase_reg <= phase_next;
            sh_reg <= sh_next;
        end
    end

    // Position borrow and zero detection follow the field bit by bit.
    always_ff @(posedge sclk) begin
        if (!link_rstn_reg) begin
            borrow_reg <= 1'b0;
            pos_nz_reg <= 1'b0;
        end else if (in_pos && !link_in.cs_n) begin
            borrow_reg <= borrow_in && !link_in.mosi;
            pos_nz_reg <= (cur_idx != POS_FIRST_IDX) && pos_nz_reg || link_in.mosi;
        end
    end

    // Control and address fields are latched when their byte completes.
    always_ff @(posedge sclk) begin
        if (!link_rstn_reg) begin
            bcast_reg <= 1'b0;
            rnw_reg <= 1'b0;
            sel_reg <= 1'b0;
            addr_reg <= '0;
            tx_reg <= READ_ZERO;
        end else if (!link_in.cs_n && byte_done) begin
            if (phase_next == BYTE_CONTROL) begin
                bcast_reg <= sh_next[BROADCAST_POS];
                rnw_reg <= sh_next[READ_POS];
                sel_reg <= pos_zero;
            end else if (phase_next == BYTE_ADDRESS) begin
                addr_reg <= sh_next;
                tx_reg <= addr_ok ? sync_bank_reg[sh_next[1:0]] : READ_ZERO;
            end
        end
    end

    // The finished word is held until the next packet, which outlasts its crossing.
    always_ff @(posedge sclk) begin
        if (!link_rstn_reg) begin
            word_reg <= '0;
            wr_toggle_reg <= 1'b0;
        end else if (!link_in.cs_n && byte_done && phase_next == BYTE_PAYLOAD
                     && write_ok && addr_reg < REG_LIMIT) begin
            word_reg <= '{addr: addr_reg, data: sh_next};
            wr_toggle_reg <= !wr_toggle_reg;
        end
    end

    // ------------------------------------------------------------------
    // Read data output
    // ------------------------------------------------------------------
    wire drive_slot = read_hit && ((phase_reg == BYTE_ADDRESS && new_byte)
                      || (phase_reg == BYTE_PAYLOAD && !new_byte));
    wire [2:0] tx_idx = (phase_reg == BYTE_PAYLOAD) ? 3'(LAST_BIT_IDX - cur_idx) : LAST_BIT_IDX;

    // Data changes on falling edges so it is settled at the master's rising edge.
    always_ff @(negedge sclk) begin
        if (!link_rstn_reg || !drive_slot) begin
            miso_oe_n <= 1'b1;
            miso_out <= 1'b0;
        end else begin
            miso_oe_n <= 1'b0;
            miso_out <= tx_reg[tx_idx];
        end
    end

    // ------------------------------------------------------------------
    // Crossing into clk
    // ------------------------------------------------------------------
    logic [2:0] tog_sync_reg;
    logic cs_meta_reg;
    logic cs_high_reg;
    logic pending_reg;
    logic [7:0] bank_reg [REG_COUNT];
    wire tog_edge = tog_sync_reg[2] ^ tog_sync_reg[1];
    wire push = pending_reg && cs_high_reg;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [FIFO_WIDTH-1:0] fifo_out_data;
    wr_word_type drain_word;
    wire drain = fifo_out_valid && !hold_updates;
    assign drain_word = wr_word_type'(fifo_out_data);
    wire drain_hit = drain && (drain_word.addr < REG_LIMIT);

    // Toggle and select level pass two flops before any logic looks at them.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            tog_sync_reg <= '0;
            cs_meta_reg <= 1'b1;
            cs_high_reg <= 1'b1;
        end else begin
            tog_sync_reg <= {tog_sync_reg[1:0], wr_toggle_reg};
            cs_meta_reg <= link_in.cs_n;
            cs_high_reg <= cs_meta_reg;
        end
    end

    // A finished word waits for select release and for room in the FIFO.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            pending_reg <= 1'b0;
        end else if (tog_edge) begin
            pending_reg <= 1'b1;
        end else if (push && fifo_in_ready) begin
            pending_reg <= 1'b0;
        end
    end

    write_fifo #(
        .WIDTH(FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rstn(rstn),
        .in_valid(push),
        .in_ready(fifo_in_ready),
        .in_data(FIFO_WIDTH'(word_reg)),
        .out_valid(fifo_out_valid),
        .out_ready(!hold_updates),
        .out_data(fifo_out_data)
    );

    // ------------------------------------------------------------------
    // Register bank
    // ------------------------------------------------------------------
    // Each entry takes only its own address; others stay untouched.
    // The link copy is a quasi-static snapshot: entries change only on writes.
    for (genvar i = 0; i < REG_COUNT; i++) begin : g_bank
        always_ff @(posedge clk) begin
            if (!rstn) begin
                bank_reg[i] <= REG_RESET;
            end else if (drain_hit && drain_word.addr == 8'(i)) begin
                bank_reg[i] <= drain_word.data;
            end
        end
        always_ff @(posedge sclk) begin
            sync_meta_reg[i] <= bank_reg[i];
            sync_bank_reg[i] <= sync_meta_reg[i];
        end
        assign reg_bank[i*8 +: 8] = bank_reg[i];
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    logic [7:0] out_sh_reg;
    always_ff @(posedge sclk) begin
        out_sh_reg <= {out_sh_reg[6:0], chain_data_out};
    end
    function automatic logic [4:0] rev5(input logic [4:0] v);
        rev5 = {v[0], v[1], v[2], v[3], v[4]};
    endfunction : rev5

    pos_minus_a: assert property (@(posedge sclk) disable iff (!link_rstn_reg)
        (!link_in.cs_n && byte_done && phase_next == BYTE_CONTROL)
        |=> rev5(out_sh_reg[4:0]) == 5'(rev5(sh_reg[4:0]) - 5'h01))
        else $error("Forwarded chain position is not one less.");
    // Every bit but the position field is compared after its byte ends, so a misplaced decrement window shows up.
    pass_thru_a: assert property (@(posedge sclk) disable iff (!link_rstn_reg)
        (!link_in.cs_n && byte_done) |=> out_sh_reg[7:5] == sh_reg[7:5]
        && (phase_reg == BYTE_CONTROL || out_sh_reg[4:0] == sh_reg[4:0]))
        else $error("Non-position bit altered on chain output.");
    write_quiet_a: assert property (@(posedge sclk) disable iff (!link_rstn_reg)
        (!rnw_reg && phase_reg != BYTE_CONTROL) |-> miso_oe_n)
        else $error("Data output driven during a write.");
    resync_a: assert property (@(posedge sclk) disable iff (!link_rstn_reg)
        link_in.cs_n |=> (bit_cnt_reg == BIT_CNT_ZERO && phase_reg == BYTE_CONTROL))
        else $error("Released select did not restart the packet.");
    write_gate_a: assert property (@(posedge sclk) disable iff (!link_rstn_reg)
        $changed(wr_toggle_reg) |-> $past(write_ok) && $past(phase_next) == BYTE_PAYLOAD)
        else $error("Write accepted without broadcast or selection.");
    unmapped_link_a: assert property (@(posedge sclk) disable iff (!link_rstn_reg)
        $changed(wr_toggle_reg) |-> word_reg.addr < REG_LIMIT)
        else $error("Unmapped write word forwarded.");
    read_zero_a: assert property (@(posedge sclk) disable iff (!link_rstn_reg)
        (!link_in.cs_n && byte_done && phase_next == BYTE_ADDRESS && !addr_ok)
        |=> tx_reg == READ_ZERO)
        else $error("Unmapped read does not return zeros.");
    commit_release_a: assert property (@(posedge clk) disable iff (!rstn)
        (pending_reg && !cs_high_reg) |=> pending_reg)
        else $error("Write committed before select release.");
    bank_keep_a: assert property (@(posedge clk) disable iff (!rstn)
        !drain_hit |=> $stable(reg_bank))
        else $error("Bank changed without a mapped write.");

    bcast_write_c: cover property (@(posedge sclk) disable iff (!link_rstn_reg)
        $changed(wr_toggle_reg) && bcast_reg && !sel_reg);
    read_drive_c: cover property (@(posedge sclk) disable iff (!link_rstn_reg)
        !miso_oe_n);
    bank_update_c: cover property (@(posedge clk) disable iff (!rstn) drain_hit);
endmodule : spi_chain_write

// ---- testbench/spi_master_model.sv ----
// Behavioural serial master that frames three-byte packets for the chained write slave.
// Assumes the slave samples data on rising sclk and drives its data output from falling sclk.
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Serial master model
// ----------------------------------------------------------------------
module spi_master_model (
    output logic sclk,
    output spi_chain_pkg::link_in_type link_in,
    input wire logic chain_data_out,
    input wire logic miso_out,
    input wire logic miso_oe_n
);
    import spi_chain_pkg::*;
    localparam realtime HALF = 32.0;
    logic [23:0] fwd_pkt;
    logic [2:0] oe_seen;
    logic [7:0] rx_byte;
    logic [7:0] cur_fwd;

    // The clock stands still between frames, so the slave sees no stray edges.
    initial begin
        sclk = 1'h0;
        link_in.cs_n = 1'h1;
        link_in.mosi = 1'h0;
        fwd_pkt = '0;
        oe_seen = '0;
        rx_byte = '0;
        cur_fwd = '0;
    end

    // Shifts the top n bits of tx, first bit first; a short count models an aborted byte.
    // The forwarded bit is taken just before the rising edge, where a downstream slave samples.
    task automatic shift_bits(input logic [7:0] tx, input int n, input int idx);
        link_in.cs_n = 1'h0;
        for (int i = 7; i > 7 - n; i--) begin
            link_in.mosi = tx[i];
            #HALF;
            cur_fwd[i] = chain_data_out;
            sclk = 1'h1;
            if (miso_oe_n !== 1'h1)
                oe_seen[idx] = 1'h1;
            // Separate data wires, so the master never drives the slave's output line.
            rx_byte[i] = miso_oe_n ? 1'hz : miso_out;
            #HALF;
            sclk = 1'h0;
        end
        fwd_pkt[8*(2-idx) +: 8] = cur_fwd;
        #HALF;
        link_in.cs_n = 1'h1;
        // A deselected line must not look like it still holds the last bit.
        link_in.mosi = ~link_in.mosi;
        #(3*HALF);
    endtask : shift_bits

    // The odd offset keeps the link timing unrelated in phase to the system clock.
    task automatic send_packet(input logic [7:0] ctrl, input logic [7:0] addr,
                               input logic [7:0] data);
        oe_seen = 3'h0;
        #(HALF + 1.3);
        shift_bits(ctrl, 8, 0);
        shift_bits(addr, 8, 1);
        shift_bits(data, 8, 2);
    endtask : send_packet

    // A rising clock with select released puts the slave back at the control byte.
    task automatic idle_pulses(input int n);
        for (int i = 0; i < n; i++) begin
            #HALF;
            sclk = 1'h1;
            #HALF;
            sclk = 1'h0;
        end
    endtask : idle_pulses
endmodule : spi_master_model

// ---- testbench/spi_chain_write_bench.sv ----
// Self-checking bench for the chained serial write slave.
// Assumes the master model drives the link on its own clock and the bench owns clk domain inputs.
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Bench top
// ----------------------------------------------------------------------
module spi_chain_write_bench;
    import spi_chain_pkg::*;
    logic clk;
    logic rstn;
    logic sclk;
    logic hold_updates;
    logic chain_data_out;
    logic miso_out;
    logic miso_oe_n;
    link_in_type link_in;
    logic [REG_COUNT*8-1:0] reg_bank;
    logic [REG_COUNT*8-1:0] exp_bank;
    int n_mismatch;
    int check_count;

    spi_chain_write u_dut (
        .clk(clk),
        .rstn(rstn),
        .sclk(sclk),
        .link_in(link_in),
        .hold_updates(hold_updates),
        .chain_data_out(chain_data_out),
        .miso_out(miso_out),
        .miso_oe_n(miso_oe_n),
        .reg_bank(reg_bank)
    );

    spi_master_model u_master (
        .sclk(sclk),
        .link_in(link_in),
        .chain_data_out(chain_data_out),
        .miso_out(miso_out),
        .miso_oe_n(miso_oe_n)
    );

    // System clock at 100 MHz.
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end

    // ----------------------------------------------------------------------
    // Shared helpers
    // ----------------------------------------------------------------------
    // Case inequality so that an unknown never passes as a match.
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // Waits a bounded time for the bank to reach its expected value, then a little longer
    // so that a late stray write is caught as well.
    task automatic settle();
        for (int i = 0; i < 40 && reg_bank !== exp_bank; i++)
            @(posedge clk);
        repeat (10) @(posedge clk);
        #1;
        check("reg_bank", exp_bank, reg_bank);
    endtask : settle

    // One whole packet; judges the repeated stream, the data output drive on writes and the bank.
    task automatic packet(input logic [7:0] ctrl, input logic [7:0] addr, input logic [7:0] data,
                          input logic [7:0] fwd_ctrl);
        @(posedge clk);
        u_master.send_packet(ctrl, addr, data);
        check("forwarded packet", {8'h00, fwd_ctrl, addr, data}, {8'h00, u_master.fwd_pkt});
        if (ctrl[6] === 1'h0)
            check("write drive", 32'h0, {29'h0, u_master.oe_seen});
        settle();
    endtask : packet

    // ----------------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------------
    task automatic test_target_write();
        exp_bank[15:8] = 8'hA5;
        packet(8'h00, 8'h01, 8'hA5, 8'h1F);
        $display("done: target write");
    endtask : test_target_write

    // Positions 1, 12 and 31 plain, then 12 with broadcast; fields are bit reversed.
    task automatic test_chain();
        logic [31:0] ctl_tab;
        logic [31:0] fwd_tab;
        ctl_tab = 32'h10061F86;
        fwd_tab = 32'h001A0F9A;
        for (int i = 0; i < 4; i++) begin
            if (ctl_tab[31-8*i] === 1'h1)
                exp_bank[23:16] = 8'h30 + 8'(i);
            packet(ctl_tab[31-8*i -: 8], 8'h02, 8'h30 + 8'(i), fwd_tab[31-8*i -: 8]);
        end
        $display("done: chain positions");
    endtask : test_chain

    task automatic test_unmapped();
        packet(8'h00, 8'h04, 8'h77, 8'h1F);
        packet(8'h00, 8'hFF, 8'h77, 8'h1F);
        $display("done: unmapped writes");
    endtask : test_unmapped

    // A data byte cut short must not land; the resync edge restores packet framing.
    task automatic test_abort();
        @(posedge clk);
        u_master.shift_bits(8'h00, 8, 0);
        u_master.shift_bits(8'h03, 8, 1);
        u_master.shift_bits(8'h99, 5, 2);
        u_master.idle_pulses(1);
        settle();
        exp_bank[31:24] = 8'h5A;
        packet(8'h00, 8'h03, 8'h5A, 8'h1F);
        $display("done: abort and resync");
    endtask : test_abort

    // The third byte the master sends in a read must not be written anywhere.
    task automatic test_read();
        packet(8'h40, 8'h01, 8'h66, 8'h5F);
        check("read data", {24'h0, exp_bank[15:8]}, {24'h0, u_master.rx_byte});
        check("read drive bytes", 32'h4, {29'h0, u_master.oe_seen});
        packet(8'h40, 8'h05, 8'h66, 8'h5F);
        check("unmapped read", 32'h0, {24'h0, u_master.rx_byte});
        packet(8'h50, 8'h01, 8'h66, 8'h40);
        check("unselected read drive", 32'h0, {29'h0, u_master.oe_seen});
        $display("done: reads");
    endtask : test_read

    // Nine writes while the bank is stalled: eight fill the FIFO, the ninth waits its turn.
    task automatic test_hold();
        @(posedge clk);
        #1;
        hold_updates = 1'h1;
        for (int i = 0; i < 9; i++)
            packet(8'h00, 8'(i % 4), 8'hE0 + 8'(i), 8'h1F);
        exp_bank = 32'hE7E6E5E8;
        @(posedge clk);
        #1;
        hold_updates = 1'h0;
        settle();
        $display("done: stalled drain");
    endtask : test_hold

    // ----------------------------------------------------------------------
    // Sequence and verdict
    // ----------------------------------------------------------------------
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : report_and_stop

    // The link side resets only on serial clock edges, so pulses run during reset.
    initial begin
        n_mismatch = 0;
        check_count = 0;
        rstn = 1'h0;
        hold_updates = 1'h0;
        exp_bank = '0;
        u_master.idle_pulses(4);
        repeat (4) @(posedge clk);
        #1;
        rstn = 1'h1;
        u_master.idle_pulses(4);
        check("reset bank", 32'h0, reg_bank);
        test_target_write();
        test_chain();
        test_unmapped();
        test_abort();
        test_read();
        test_hold();
        report_and_stop();
    end

    // About twenty packets of a few microseconds each; the limit leaves wide margin.
    initial begin
        #300000;
        n_mismatch++;
        report_and_stop();
    end
endmodule : spi_chain_write_bench
